// ===== src/pcu_pipe.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcu_defines.svh"

module pcu_pipe import pcu_pkg::*; (
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Instruction memory
    output logic [15:0] fetch_addr_o,
    output logic fetch_req_o,
    input wire logic [15:0] fetch_data_i,
    input wire logic mem_wait_i,
    // Interrupt
    input wire logic irq_i,
    output logic irq_ack_o,
    // Status
    output logic retire_o,
    output logic [15:0] wb_data_o,
    output logic md_busy_o
);

    localparam logic [3:0] MUL_STEPS = 4'(`PCU_MUL_MC - 1);
    localparam logic [3:0] DIV_STEPS = 4'(`PCU_DIV_MC - 1);
    localparam logic [1:0] PH_LAST = 2'(`PCU_MCYC_CLKS - 1);

    // Restoring divide step: one quotient bit
    function automatic logic [31:0] div_step(input logic [31:0] rq,
                                             input logic [15:0] d);
        logic [16:0] t;
        logic [16:0] s;
        t = rq[31:15];
        s = t - {1'b0, d};
        if (t >= {1'b0, d})
            div_step = {s[15:0], rq[14:0], 1'b1};
        else
            div_step = {t[15:0], rq[14:0], 1'b0};
    endfunction : div_step

    // Sign extension of an 8-bit field
    function automatic logic [15:0] sext8(input logic [7:0] v);
        sext8 = {{8{v[7]}}, v};
    endfunction : sext8

    // Machine cycle phase and advance strobe
    logic [1:0] ph;
    logic adv;
    assign adv = ce_i && (ph == PH_LAST) && !mem_wait_i;

    // Stage registers
    logic [15:0] ip;
    logic d_valid;
    logic [15:0] d_instr;
    logic [15:0] d_ip;
    logic e_valid;
    pcu_op_t e_op;
    logic [3:0] e_rd;
    logic [15:0] e_a;
    logic [15:0] e_b;
    logic [15:0] e_c;
    logic [15:0] e_ip;
    logic w_valid;
    logic w_we;
    logic w_we2;
    logic [3:0] w_rd;
    logic [15:0] w_res;
    logic [15:0] w_res2;
    logic [15:0] regs [16];

    // Multiply/divide unit
    pcu_md_t md_state;
    logic [3:0] md_cnt;
    logic [15:0] md_hi;
    logic [15:0] md_lo;
    logic [15:0] md_m;
    logic [15:0] md_nhi;
    logic [15:0] md_nlo;

    // Jump cache
    logic jc_valid;
    logic jc_fill;
    logic [15:0] jc_ip;
    logic [15:0] jc_tgt;
    logic [15:0] jc_instr;

    // Decode fields, combinational, no microcode
    pcu_op_t d_op;
    logic [3:0] d_rd;
    logic [3:0] d_rs;
    assign d_op = pcu_op_t'(d_instr[`PCU_OP_HI:`PCU_OP_LO]);
    assign d_rd = d_instr[`PCU_RD_HI:`PCU_RD_LO];
    assign d_rs = d_instr[`PCU_RS_HI:`PCU_RS_LO];

    // Execute results
    logic e_md;
    logic e_we;
    logic [15:0] ex_res;
    logic [15:0] ex_res2;
    logic [31:0] rot2;
    assign e_md = e_valid && (e_op == OP_MUL || e_op == OP_DIV);
    assign e_we = e_valid && !(e_op == OP_BZ || e_op == OP_BNZ
                               || e_op == OP_NOP);
    assign rot2 = {e_a, e_a} >> e_b[3:0];

    // ALU, barrel shifter, bit-mask generator, muldiv result
    always_comb begin
        ex_res = 16'h0000;
        ex_res2 = md_nhi;
        case (e_op)
            OP_ADD: ex_res = e_a + e_b;
            OP_SUB: ex_res = e_a - e_b;
            OP_AND: ex_res = e_a & e_b;
            OP_OR: ex_res = e_a | e_b;
            OP_XOR: ex_res = e_a ^ e_b;
            OP_SHL: ex_res = e_a << e_b[3:0];
            OP_ROR: ex_res = rot2[15:0];
            OP_BSET: ex_res = e_a | (16'h0001 << e_b[3:0]);
            OP_MUL: ex_res = md_nlo;
            OP_DIV: ex_res = md_nlo;
            OP_LDI: ex_res = e_b;
            default: ex_res = 16'h0000;
        endcase
    end

    // Operand forwarding: execute, then write back, then register file
    function automatic logic [15:0] fwd(input logic [3:0] idx);
        if (e_we && e_rd == idx)
            fwd = ex_res;
        else if (e_md && (e_rd ^ 4'h1) == idx)
            fwd = ex_res2;
        else if (w_valid && w_we && w_rd == idx)
            fwd = w_res;
        else if (w_valid && w_we2 && (w_rd ^ 4'h1) == idx)
            fwd = w_res2;
        else
            fwd = regs[idx];
    endfunction : fwd

    // Operand read in decode
    logic [15:0] d_a;
    logic [15:0] d_b;
    logic [15:0] d_c;
    logic imm_b;
    assign imm_b = d_op == OP_SHL || d_op == OP_ROR || d_op == OP_BSET;

    // A process, so that every forwarding source wakes the operand read
    always_comb begin
        d_a = fwd(d_rd);
        d_c = fwd(d_rd ^ 4'h1);
        d_b = (d_op == OP_LDI) ? sext8(d_instr[7:0]) :
              imm_b ? {12'h000, d_instr[3:0]} : fwd(d_rs);
    end

    // Stall, abort, branch resolution in decode
    logic md_last;
    logic md_stall;
    logic abort;
    logic taken;
    logic jc_hit;
    logic [15:0] target;
    assign md_last = md_state == MD_RUN && md_cnt == 4'h1;
    assign md_stall = e_md && !md_last;
    assign abort = e_md && irq_i;
    assign target = d_ip + sext8(d_instr[7:0]) + 16'h0001;
    assign taken = d_valid && !md_stall && !abort
                   && ((d_op == OP_BZ && d_a == 16'h0000)
                   || (d_op == OP_BNZ && d_a != 16'h0000));
    assign jc_hit = jc_valid && jc_ip == d_ip && jc_tgt == target;

    // Next multiply/divide partial values
    logic [19:0] mprod;
    logic [31:0] dv1;
    logic [31:0] dv2;
    assign mprod = {4'h0, md_hi} + md_m * md_lo[3:0];
    assign dv1 = div_step({md_hi, md_lo}, md_m);
    assign dv2 = div_step(dv1, md_m);

    always_comb begin
        md_nhi = md_hi;
        md_nlo = md_lo;
        if (e_op == OP_MUL) begin
            md_nhi = mprod[19:4];
            md_nlo = {mprod[3:0], md_lo[15:4]};
        end else if (!(e_op == OP_DIV && md_last)) begin
            md_nhi = dv2[31:16]; // Last divide cycle passes values through
            md_nlo = dv2[15:0];
        end
    end

    // Machine cycle phase counter
    always_ff @(posedge clock_i) begin
        if (!rst_n_i)
            ph <= 2'h0;
        else if (ce_i)
            ph <= (ph == PH_LAST) ? 2'h0 : ph + 2'h1;
    end

    // Fetch stage and instruction pointer
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ip <= `PCU_IP_RESET;
            d_valid <= 1'b0;
            d_instr <= `PCU_NOP_WORD;
            d_ip <= `PCU_IP_RESET;
        end else if (adv) begin
            if (abort) begin
                ip <= e_ip;
                d_valid <= 1'b0;
            end else if (taken && jc_hit) begin
                ip <= target + 16'h0001;
                d_valid <= 1'b1;
                d_instr <= jc_instr;
                d_ip <= target;
            end else if (taken) begin
                ip <= target;
                d_valid <= 1'b0;
            end else if (!md_stall) begin
                ip <= ip + 16'h0001;
                d_valid <= 1'b1;
                d_instr <= fetch_data_i;
                d_ip <= ip;
            end
        end
    end

    // Decode to execute control register
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            e_valid <= 1'b0;
            e_op <= OP_NOP;
            e_rd <= 4'h0;
            e_a <= 16'h0000;
            e_b <= 16'h0000;
            e_c <= 16'h0000;
            e_ip <= `PCU_IP_RESET;
        end else if (adv && !md_stall) begin
            e_valid <= d_valid && !abort;
            e_op <= d_op;
            e_rd <= d_rd;
            e_a <= d_a;
            e_b <= d_b;
            e_c <= d_c;
            e_ip <= d_ip;
        end else if (adv && abort) begin
            e_valid <= 1'b0;
        end
    end

    // Multiply/divide sequencer
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            md_state <= MD_IDLE;
            md_cnt <= 4'h0;
            md_hi <= 16'h0000;
            md_lo <= 16'h0000;
            md_m <= 16'h0000;
        end else if (adv) begin
            case (md_state)
                MD_IDLE: begin
                    if (e_md && !abort) begin
                        md_state <= MD_RUN;
                        md_cnt <= (e_op == OP_MUL) ? MUL_STEPS : DIV_STEPS;
                        md_hi <= (e_op == OP_MUL) ? 16'h0000 : e_c;
                        md_lo <= (e_op == OP_MUL) ? e_b : e_a;
                        md_m <= (e_op == OP_MUL) ? e_a : e_b;
                    end
                end
                MD_RUN: begin
                    md_hi <= md_nhi;
                    md_lo <= md_nlo;
                    md_cnt <= md_cnt - 4'h1;
                    if (abort || md_last)
                        md_state <= MD_IDLE;
                end
                default: md_state <= MD_IDLE;
            endcase
        end
    end

    // Execute to write back control register
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            w_valid <= 1'b0;
            w_we <= 1'b0;
            w_we2 <= 1'b0;
            w_rd <= 4'h0;
            w_res <= 16'h0000;
            w_res2 <= 16'h0000;
        end else if (adv) begin
            w_valid <= e_valid && !md_stall && !abort;
            w_we <= e_we;
            w_we2 <= e_md;
            w_rd <= e_rd;
            w_res <= ex_res;
            w_res2 <= ex_res2;
        end
    end

    // Write back into the register file
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 16; i++)
                regs[i] <= 16'h0000;
        end else if (adv && w_valid) begin
            if (w_we)
                regs[w_rd] <= w_res;
            if (w_we2)
                regs[w_rd ^ 4'h1] <= w_res2;
        end
    end

    // Jump cache fill on backward taken branch that missed
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            jc_valid <= 1'b0;
            jc_fill <= 1'b0;
            jc_ip <= 16'h0000;
            jc_tgt <= 16'h0000;
            jc_instr <= `PCU_NOP_WORD;
        end else if (adv) begin
            if (taken && !jc_hit && d_instr[7]) begin
                jc_fill <= 1'b1;
                jc_valid <= 1'b0;
                jc_ip <= d_ip;
                jc_tgt <= target;
            end else if (jc_fill && !abort) begin
                jc_fill <= 1'b0;
                jc_valid <= 1'b1;
                jc_instr <= fetch_data_i;
            end
        end
    end

    // Registered status outputs
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            fetch_req_o <= 1'b0;
            irq_ack_o <= 1'b0;
            retire_o <= 1'b0;
            wb_data_o <= 16'h0000;
            md_busy_o <= 1'b0;
        end else if (ce_i) begin
            fetch_req_o <= 1'b1;
            irq_ack_o <= adv && abort;
            retire_o <= adv && w_valid;
            if (adv && w_valid && w_we)
                wb_data_o <= w_res;
            md_busy_o <= md_state == MD_RUN;
        end
    end

    assign fetch_addr_o = ip;

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    mcyc_gap_a: assert property (adv |=> !adv)
        else $error("advance on consecutive clocks");
    wait_hold_a: assert property (ce_i && mem_wait_i |=>
        $stable(d_instr) && $stable(e_op) && $stable(ip))
        else $error("stage registers moved during wait");
    pipe_flow_a: assert property (adv && d_valid && !md_stall
        && !abort |=> e_valid)
        else $error("decoded word did not enter execute");
    ip_step_a: assert property (adv && !md_stall && !taken
        && !abort |=> ip == $past(ip) + 16'h0001)
        else $error("pointer did not step");
    branch_miss_a: assert property (adv && taken && !jc_hit
        |=> !d_valid && ip == $past(target))
        else $error("taken branch not refetched");
    jc_hit_a: assert property (adv && taken && jc_hit
        |=> d_valid && d_ip == $past(target))
        else $error("cached branch lost a cycle");
    shift_one_a: assert property (adv && e_valid
        && e_op == OP_SHL |=> w_valid && w_res == $past(ex_res))
        else $error("shift took more than one cycle");
    md_len_a: assert property (adv && md_state == MD_IDLE && e_md
        && !abort |=> md_cnt == ((e_op == OP_MUL) ? 4'h4 : 4'h9))
        else $error("muldiv length wrong");
    md_abort_a: assert property (adv && abort
        |=> md_state == MD_IDLE && irq_ack_o && !e_valid)
        else $error("muldiv not aborted");
    wb_store_a: assert property (adv && w_valid && w_we && !w_we2
        |=> regs[$past(w_rd)] == $past(w_res))
        else $error("result not written back");

endmodule : pcu_pipe
`default_nettype wire

// ===== common/pcu_defines.svh
// Contract
// - Four pipeline stages each hold a different instruction at once.
// - Fetch reads the word at the instruction pointer from any memory.
// - Decode decodes the prior fetched word and reads its operands.
// - Execute performs the decoded operation on the decode operands.
// - Write back stores the result in the named destination register.
// - Shifts and rotates finish in one machine cycle for any distance.
// - Taken branch costs one extra machine cycle; untaken costs none.
// - A jump cache removes the penalty for most loop closing branches.
// - One machine cycle lasts 80 ns at the 25 MHz clock.
// - Divide takes 0.8 us and multiply 0.4 us at 25 MHz.
// - Decode is combinational; outputs travel in stage control registers.
// - External wait states hold every stage control register unchanged.
// - Multi-cycle work uses small state machines that override control.
// - Execute holds ALU, muldiv unit, bit-mask generator, barrel shifter.
// - One instruction per cycle; multiply 4+1, divide 9+1 machine cycles.
// - Multiply and divide in progress abort on an interrupt request.
`ifndef PCU_DEFINES_SVH
`define PCU_DEFINES_SVH

// Clock and machine cycle timing
`define PCU_CLK_NS 40
`define PCU_MCYC_NS 80
`define PCU_MCYC_CLKS ((`PCU_MCYC_NS + `PCU_CLK_NS - 1) / `PCU_CLK_NS)
`define PCU_MUL_NS 400
`define PCU_DIV_NS 800
`define PCU_MUL_MC (`PCU_MUL_NS / `PCU_MCYC_NS)
`define PCU_DIV_MC (`PCU_DIV_NS / `PCU_MCYC_NS)
// Instruction word fields
`define PCU_OP_HI 15
`define PCU_OP_LO 12
`define PCU_RD_HI 11
`define PCU_RD_LO 8
`define PCU_RS_HI 7
`define PCU_RS_LO 4
// Reset values
`define PCU_IP_RESET 16'h0000
`define PCU_NOP_WORD 16'hf000

`endif

// ===== common/pcu_pkg.sv
`default_nettype none
package pcu_pkg;
    // Operation codes in the top nibble of an instruction word
    typedef enum logic [3:0] {
        OP_ADD = 4'h0, OP_SUB = 4'h1, OP_AND = 4'h2, OP_OR = 4'h3,
        OP_XOR = 4'h4, OP_SHL = 4'h5, OP_ROR = 4'h6, OP_BSET = 4'h7,
        OP_MUL = 4'h8, OP_DIV = 4'h9, OP_BZ = 4'ha, OP_BNZ = 4'hb,
        OP_LDI = 4'hc, OP_NOP = 4'hf
    } pcu_op_t;

    // Multiply/divide sequencer states, one-hot
    typedef enum logic [1:0] {
        MD_IDLE = 2'b01,
        MD_RUN = 2'b10
    } pcu_md_t;
endpackage : pcu_pkg
`default_nettype wire

// ===== test/pcu_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module pcu_mem_model (
    // Clock
    input wire logic clock_i,
    // Fetch side
    input wire logic [15:0] fetch_addr_i,
    input wire logic fetch_req_i,
    output logic [15:0] fetch_data_o,
    output logic mem_wait_o,
    // Loading and pacing
    input wire logic slow_i,
    input wire logic load_en_i,
    input wire logic [5:0] load_addr_i,
    input wire logic [15:0] load_data_i
);
    logic [15:0] mem [64];
    logic [15:0] last_addr = 16'h0000;
    logic [15:0] junk = 16'h5a5a;
    logic [1:0] wait_cnt = 2'h0;

    // Program load, wait states on each new address, changing filler
    always @(posedge clock_i) begin
        if (load_en_i) begin
            mem[load_addr_i] <= load_data_i;
        end
        last_addr <= fetch_addr_i;
        junk <= junk + 16'h9e37;
        if (slow_i && fetch_addr_i != last_addr) begin
            wait_cnt <= 2'($urandom_range(3, 0));
        end else if (wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
        end
    end

    // Word is valid only when requested and not waiting
    assign mem_wait_o = wait_cnt != 2'h0;
    assign fetch_data_o = (fetch_req_i && !mem_wait_o) ?
        mem[fetch_addr_i[5:0]] : junk;
endmodule : pcu_mem_model

`default_nettype wire

// ===== test/cpu_four_stage_pipeline_tb.sv
`timescale 1ns/1ps
`default_nettype none

module cpu_four_stage_pipeline_tb import pcu_pkg::*;;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic irq_i = 1'b0;
    logic ce = 1'b1;
    logic slow = 1'b0;
    logic ld_en = 1'b0;
    logic [5:0] ld_addr = 6'h00;
    logic [15:0] ld_data = 16'h0000;
    logic [15:0] fetch_addr_o, fetch_data_i, wb_data_o, a_prev;
    logic fetch_req_o, mem_wait_i, irq_ack_o, retire_o, md_busy_o;
    logic w_prev = 1'b0;
    logic [15:0] prog[$], ev[$], rv[$];
    int gp[$], rt[$];
    int cyc = 0;
    int miscompares = 0;
    int checks_done = 0;

    // 25 MHz clock
    always #20 clock_i = ~clock_i;

    pcu_pipe DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce),
        .fetch_addr_o(fetch_addr_o), .fetch_req_o(fetch_req_o),
        .fetch_data_i(fetch_data_i), .mem_wait_i(mem_wait_i),
        .irq_i(irq_i), .irq_ack_o(irq_ack_o), .retire_o(retire_o),
        .wb_data_o(wb_data_o), .md_busy_o(md_busy_o));

    pcu_mem_model mem (.clock_i(clock_i), .fetch_addr_i(fetch_addr_o),
        .fetch_req_i(fetch_req_o), .fetch_data_o(fetch_data_i),
        .mem_wait_o(mem_wait_i), .slow_i(slow), .load_en_i(ld_en),
        .load_addr_i(ld_addr), .load_data_i(ld_data));

    task automatic cmp_v(string what, logic [15:0] exp, logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_v

    task automatic cmp_n(string what, int exp, int got);
        checks_done++;
        if (got != exp) begin
            miscompares++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask : cmp_n

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    // Retire log, address hold under wait states, time limit
    always @(negedge clock_i) begin
        cyc++;
        if (retire_o === 1'b1 && ce) begin // Pulse holds while frozen
            rv.push_back(wb_data_o);
            rt.push_back(cyc);
        end
        if (w_prev) begin
            cmp_v("held address", a_prev, fetch_addr_o);
        end
        a_prev = fetch_addr_o;
        w_prev = (mem_wait_i === 1'b1);
        // Random clock-enable gaps, slow pass only
        ce = !slow || ($urandom_range(3, 0) != 0);
        if (cyc > 3000) begin
            miscompares++;
            end_of_test();
        end
    end

    function automatic logic [15:0] mk(pcu_op_t op, logic [3:0] rd,
                                       logic [7:0] f);
        return {op, rd, f};
    endfunction : mk

    // Expected results of a straight-line program
    function automatic void iss();
        logic [15:0] r [16];
        logic [31:0] p;
        logic [15:0] a, b, last;
        logic [3:0] d, n;
        last = 16'h0000;
        r = '{default: 16'h0000};
        ev.delete();
        foreach (prog[i]) begin
            d = prog[i][11:8];
            n = prog[i][3:0];
            a = r[d];
            b = r[prog[i][7:4]];
            p = {r[d ^ 4'h1], a};
            case (prog[i][15:12])
                OP_ADD: r[d] = a + b;
                OP_SUB: r[d] = a - b;
                OP_AND: r[d] = a & b;
                OP_OR: r[d] = a | b;
                OP_XOR: r[d] = a ^ b;
                OP_SHL: r[d] = a << n;
                OP_ROR: r[d] = (a >> n) | (a << (5'd16 - n));
                OP_BSET: r[d] = a | (16'h0001 << n);
                OP_MUL: {r[d ^ 4'h1], r[d]} = a * b;
                OP_DIV: begin
                    r[d] = 16'(p / b);
                    r[d ^ 4'h1] = 16'(p % b);
                end
                OP_LDI: r[d] = {{8{prog[i][7]}}, prog[i][7:0]};
                default: ;
            endcase
            if (prog[i][15:12] <= 4'h9 || prog[i][15:12] == 4'hc) begin
                last = r[d];
            end
            ev.push_back(last);
        end
    endfunction : iss

    // Load under reset, release, optional abort, then compare retires
    task automatic run(string name, int n, bit abort, bit s);
        int i;
        slow = 1'b0;
        repeat (4) @(negedge clock_i);
        rst_n_i = 1'b0;
        prog.push_back(mk(OP_BZ, 4'h0, 8'hff));
        for (i = 0; i < 64; i++) begin
            @(negedge clock_i);
            ld_en = 1'b1;
            ld_addr = 6'(i);
            ld_data = i < prog.size() ? prog[i] : mk(OP_NOP, 4'h0, 8'h00);
        end
        @(negedge clock_i);
        ld_en = 1'b0;
        repeat (5) @(negedge clock_i);
        rv.delete();
        rt.delete();
        slow = s;
        rst_n_i = 1'b1;
        if (abort) begin
            for (i = 0; i < 200 && md_busy_o !== 1'b1; i++) @(negedge clock_i);
            irq_i = 1'b1;
            for (i = 0; i < 20 && irq_ack_o !== 1'b1; i++) @(negedge clock_i);
            cmp_v("abort ack", 16'h0001, {15'h0, irq_ack_o});
            irq_i = 1'b0;
            @(negedge clock_i);
            cmp_v("busy after abort", 16'h0000, {15'h0, md_busy_o});
        end
        for (i = 0; i < 2000 && rv.size() < n; i++) @(negedge clock_i);
        cmp_n("retires", n, rv.size() < n ? rv.size() : n);
        cmp_v("fetch request", 16'h0001, {15'h0, fetch_req_o});
        for (i = 0; i < n && i < rv.size(); i++) begin
            cmp_v("result", ev[i], rv[i]);
            if (i > 0 && i < gp.size() && gp[i] > 0) begin
                cmp_n("gap", gp[i], rt[i] - rt[i - 1]);
            end
        end
        $display("test %s done", name);
        prog.delete();
        gp.delete();
    endtask : run

    initial begin
        int k;
        logic [15:0] w;
        void'($urandom(32'hb925));
        // Random ALU, shift and bit-set mix, second pass with waits
        for (k = 0; k < 2; k++) begin
            prog.push_back(mk(OP_LDI, 4'h1, 8'($urandom)));
            prog.push_back(mk(OP_LDI, 4'h2, 8'($urandom)));
            prog.push_back(mk(OP_SHL, 4'h1, 8'h0f));
            prog.push_back(mk(OP_ROR, 4'h2, 8'h0f));
            repeat (14) begin
                w = 16'($urandom);
                w[15] = 1'b0;
                w[11:8] = {3'h0, w[8]} + 4'h1;
                prog.push_back(w);
            end
            gp = '{0, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2};
            if (k == 1) begin
                gp.delete();
            end
            iss();
            run(k == 1 ? "alu waits" : "alu", 18, 1'b0, k == 1);
        end
        // Multiply and divide occupancy
        k = int'($urandom_range(127, 1));
        prog = '{mk(OP_LDI, 4'h2, 8'($urandom)), mk(OP_LDI, 4'h4, 8'(k)),
            mk(OP_MUL, 4'h2, 8'h40), mk(OP_ADD, 4'h6, 8'h30),
            mk(OP_LDI, 4'h3, 8'h00), mk(OP_LDI, 4'h2, 8'($urandom)),
            mk(OP_DIV, 4'h2, 8'h40), mk(OP_ADD, 4'h7, 8'h30)};
        gp = '{0, 2, 10, 2, 2, 2, 20, 2};
        iss();
        run("muldiv", 8, 1'b0, 1'b0);
        // Multiply aborted by a request, then restarted
        prog = '{mk(OP_LDI, 4'h2, 8'($urandom)), mk(OP_LDI, 4'h4, 8'(k)),
            mk(OP_MUL, 4'h2, 8'h40), mk(OP_ADD, 4'h6, 8'h30)};
        iss();
        run("abort", 4, 1'b1, 1'b0);
        // Loop: taken miss, taken hit, fall through, untaken branch
        prog = '{mk(OP_LDI, 4'h1, 8'h03), mk(OP_LDI, 4'h2, 8'hff),
            mk(OP_ADD, 4'h1, 8'h20), mk(OP_BNZ, 4'h1, 8'hfe),
            mk(OP_LDI, 4'h3, 8'h05), mk(OP_BZ, 4'h3, 8'h05),
            mk(OP_NOP, 4'h0, 8'h00)};
        ev = '{16'h0003, 16'hffff, 16'h0002, 16'h0002, 16'h0001, 16'h0001,
            16'h0000, 16'h0000, 16'h0005, 16'h0005, 16'h0005};
        gp = '{0, 2, 2, 2, 4, 2, 2, 2, 2, 2, 2};
        run("loop", 11, 1'b0, 1'b0);
        end_of_test();
    end
endmodule : cpu_four_stage_pipeline_tb

`default_nettype wire
